// ### rtl/aira_defines.vh
// constants for the converter i2c register access block
`ifndef AIRA_DEFINES_VH
`define AIRA_DEFINES_VH
// ******************************
// bus addresses, one per select strap
// ******************************
`define AIRA_ADDR_GND 7'h48
`define AIRA_ADDR_VDD 7'h49
`define AIRA_ADDR_SDA 7'h4a
`define AIRA_ADDR_SCL 7'h4b
// strap encodings of the address-select pin
`define AIRA_SEL_GND 2'h0
`define AIRA_SEL_VDD 2'h1
`define AIRA_SEL_SDA 2'h2
`define AIRA_SEL_SCL 2'h3
// ******************************
// register pointer values
// ******************************
`define AIRA_PTR_RESULT 2'h0
`define AIRA_PTR_CONFIG 2'h1
// ******************************
// reset values
// ******************************
`define AIRA_CONFIG_RST 16'h8583
`define AIRA_PTR_RST    2'h0
`endif

// ### rtl/aira_i2c_target.v
// i2c target register access for a small converter
`timescale 1ns/1ps
`default_nettype none
`include "aira_defines.vh"
module aira_i2c_target (
	input  wire        ref_clk,
	input  wire        rst_n,
	input  wire [1:0]  addr_sel,
	input  wire        scl_in,
	output wire        scl_out,
	output wire        scl_oe,
	input  wire        sda_in,
	output wire        sda_out,
	output wire        sda_oe,
	input  wire [15:0] result_data,
	output wire [15:0] config_out,
	output wire        config_wr,
	output wire [1:0]  pointer_out,
	output wire        busy
);
	// ******************************
	// states
	// ******************************
	localparam [2:0] ST_IDLE = 3'h0; // waiting for start
	localparam [2:0] ST_ADDR = 3'h1; // shifting address byte
	localparam [2:0] ST_AACK = 3'h2; // address acknowledge slot
	localparam [2:0] ST_WR   = 3'h3; // shifting a written byte
	localparam [2:0] ST_WACK = 3'h4; // written byte acknowledge slot
	localparam [2:0] ST_RD   = 3'h5; // driving a read byte
	localparam [2:0] ST_RACK = 3'h6; // controller acknowledge slot
	localparam [2:0] ST_SKIP = 3'h7; // not ours or read over, released till start or stop

	// ******************************
	// functions
	// ******************************
	// bus address for a strap setting
	function [6:0] sel_addr;
		input [1:0] sel;
		begin
			case (sel)
				`AIRA_SEL_GND: sel_addr = `AIRA_ADDR_GND;
				`AIRA_SEL_VDD: sel_addr = `AIRA_ADDR_VDD;
				`AIRA_SEL_SDA: sel_addr = `AIRA_ADDR_SDA;
				default:       sel_addr = `AIRA_ADDR_SCL;
			endcase
		end
	endfunction
	// register contents for a pointer value
	function [15:0] reg_pick;
		input [1:0]  ptr;
		input [15:0] res;
		input [15:0] cfg;
		begin
			case (ptr)
				`AIRA_PTR_RESULT: reg_pick = res;
				`AIRA_PTR_CONFIG: reg_pick = cfg;
				default:          reg_pick = 16'h0000;
			endcase
		end
	endfunction

	// ******************************
	// registers
	// ******************************
	reg [2:0]  state_reg;    // protocol state
	reg [2:0]  bitcnt_reg;   // bit index within byte
	reg [7:0]  shift_reg;    // byte shifter
	reg [1:0]  ptr_reg;      // register pointer
	reg [15:0] cfg_reg;      // configuration register
	reg [15:0] rd_reg;       // snapshot of register being read
	reg [1:0]  wcnt_reg;     // written bytes after address
	reg [7:0]  upper_reg;    // held upper data byte
	reg        rdlow_reg;    // low byte phase of read
	reg        sda_oe_reg;   // data line pulled low
	reg        cfg_wr_reg;   // configuration write pulse
	reg        scl_d_reg;    // clock history
	reg        sda_d_reg;    // data history
	reg [1:0]  strap_reg;    // address strap caught after reset
	reg        strap_ok_reg; // strap captured
	reg        byte_rdy_reg; // eighth bit in, byte acted on at clock fall

	// line events, inputs taken synchronous to ref_clk
	wire scl_rise = scl_in & ~scl_d_reg;
	wire scl_fall = ~scl_in & scl_d_reg;
	// start and stop only while clock high
	wire start_ev = scl_in & scl_d_reg & sda_d_reg & ~sda_in;
	wire stop_ev  = scl_in & scl_d_reg & ~sda_d_reg & sda_in;
	wire [7:0] rx_byte = {shift_reg[6:0], sda_in};
	wire [15:0] sel_reg = reg_pick(ptr_reg, result_data, cfg_reg);

	// ******************************
	// strap capture, clocked after reset release
	// ******************************
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_reg    <= 2'h0;
			strap_ok_reg <= 1'b0;
		end else if (!strap_ok_reg) begin
			strap_reg    <= addr_sel;
			strap_ok_reg <= 1'b1;
		end
	end

	// ******************************
	// protocol engine
	// ******************************
	// bits sampled on clock rise, data changed on clock fall; no fixed
	// timing, so any bus speed slower than ref_clk sampling works
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg  <= ST_IDLE;
			bitcnt_reg <= 3'h0;
			shift_reg  <= 8'h00;
			ptr_reg    <= `AIRA_PTR_RST;
			cfg_reg    <= `AIRA_CONFIG_RST;
			rd_reg     <= 16'h0000;
			wcnt_reg   <= 2'h0;
			upper_reg  <= 8'h00;
			rdlow_reg  <= 1'b0;
			sda_oe_reg <= 1'b0;
			cfg_wr_reg <= 1'b0;
			byte_rdy_reg <= 1'b0;
			scl_d_reg  <= 1'b1;
			sda_d_reg  <= 1'b1;
		end else begin
			scl_d_reg  <= scl_in;
			sda_d_reg  <= sda_in;
			cfg_wr_reg <= 1'b0;
			if (stop_ev) begin
				// end of frame; pointer kept for next frame
				state_reg  <= ST_IDLE;
				sda_oe_reg <= 1'b0;
			end else if (start_ev) begin
				// start or repeated start
				state_reg  <= ST_ADDR;
				bitcnt_reg <= 3'h0;
				wcnt_reg   <= 2'h0;
				sda_oe_reg <= 1'b0;
				// a byte cut by a start must not be decoded later
				byte_rdy_reg <= 1'b0;
			end else begin
				case (state_reg)
					ST_IDLE: begin
						sda_oe_reg <= 1'b0;
					end
					ST_ADDR, ST_WR: begin
						if (scl_rise) begin
							shift_reg  <= rx_byte;
							bitcnt_reg <= bitcnt_reg + 3'h1;
							if (bitcnt_reg == 3'h7) begin
								// eighth bit in; the answer waits for the clock fall
								byte_rdy_reg <= 1'b1;
								if (state_reg == ST_WR) begin
									// pointer, upper, lower; later pairs rewrite the register
									if (wcnt_reg == 2'h2) begin
										wcnt_reg <= 2'h1;
									end else begin
										wcnt_reg <= wcnt_reg + 2'h1;
									end
									if (wcnt_reg == 2'h0) begin
										ptr_reg <= rx_byte[1:0];
									end else if (wcnt_reg == 2'h1) begin
										upper_reg <= rx_byte;
									end else if (ptr_reg == `AIRA_PTR_CONFIG) begin
										cfg_reg    <= {upper_reg, rx_byte};
										cfg_wr_reg <= 1'b1;
									end
								end
							end
						end else if (scl_fall && byte_rdy_reg) begin
							byte_rdy_reg <= 1'b0;
							if (state_reg == ST_WR) begin
								// every written byte is acknowledged, result writes too
								sda_oe_reg <= 1'b1;
								state_reg  <= ST_WACK;
							end else if (shift_reg[7:1] == sel_addr(strap_reg)) begin
								sda_oe_reg <= 1'b1;
								state_reg  <= ST_AACK;
							end else begin
								state_reg  <= ST_SKIP;
							end
						end
					end
					ST_AACK: begin
						if (scl_fall) begin
							bitcnt_reg <= 3'h0;
							if (shift_reg[0]) begin
								// read: snapshot, drive upper bit 15
								rd_reg     <= sel_reg;
								rdlow_reg  <= 1'b0;
								sda_oe_reg <= ~sel_reg[15];
								state_reg  <= ST_RD;
							end else begin
								sda_oe_reg <= 1'b0;
								wcnt_reg   <= 2'h0;
								state_reg  <= ST_WR;
							end
						end
					end
					ST_WACK: begin
						if (scl_fall) begin
							sda_oe_reg <= 1'b0;
							bitcnt_reg <= 3'h0;
							state_reg  <= ST_WR;
						end
					end
					ST_RD: begin
						if (scl_fall) begin
							bitcnt_reg <= bitcnt_reg + 3'h1;
							if (bitcnt_reg == 3'h7) begin
								sda_oe_reg <= 1'b0;
								state_reg  <= ST_RACK;
							end else begin
								sda_oe_reg <= ~rd_reg[4'hf - {1'b0, bitcnt_reg} - 4'h1];
							end
						end
					end
					ST_RACK: begin
						if (scl_rise) begin
							if (sda_in || rdlow_reg) begin
								state_reg <= ST_SKIP; // nack or both bytes sent
							end else begin
								rdlow_reg <= 1'b1;
								rd_reg    <= {rd_reg[7:0], 8'h00}; // lower byte next
							end
						end else if (scl_fall && rdlow_reg) begin
							bitcnt_reg <= 3'h0;
							sda_oe_reg <= ~rd_reg[15];
							state_reg  <= ST_RD;
						end
					end
					ST_SKIP: begin
						sda_oe_reg <= 1'b0;
					end
					default: begin
						state_reg <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// ******************************
	// outputs
	// ******************************
	// the clock line is input only: never driven, so never stretched
	assign scl_out     = 1'b0;
	assign scl_oe      = 1'b0;
	assign sda_out     = 1'b0; // open drain, only pulls low
	assign sda_oe      = sda_oe_reg;
	assign config_out  = cfg_reg;
	assign config_wr   = cfg_wr_reg;
	assign pointer_out = ptr_reg;
	assign busy        = (state_reg != ST_IDLE);
endmodule // aira_i2c_target
`default_nettype wire

// ### sim/aira_i2c_target_properties.sv
// assertions on the converter i2c target ports
`timescale 1ns/1ps
`default_nettype none
module aira_i2c_target_properties (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic [1:0]  addr_sel,
	input wire logic        scl_in,
	input wire logic        scl_out,
	input wire logic        scl_oe,
	input wire logic        sda_in,
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic [15:0] result_data,
	input wire logic [15:0] config_out,
	input wire logic        config_wr,
	input wire logic [1:0]  pointer_out,
	input wire logic        busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// frame edges: data moves while the clock stays high
	sequence start_s; scl_in && $past(scl_in) && $fell(sda_in); endsequence
	sequence stop_s; scl_in && $past(scl_in) && $rose(sda_in); endsequence
	clk_free_a: assert property (!scl_oe && !scl_out) else $error("clock driven");
	idle_quiet_a: assert property (!busy |-> !sda_oe) else $error("data pulled idle");
	start_busy_a: assert property (start_s |-> ##[1:6] busy) else $error("no frame");
	stop_idle_a: assert property (stop_s |-> ##[1:6] !busy) else $error("frame kept");
	ptr_hold_a: assert property ((!busy ##1 !busy) |-> $stable(pointer_out))
		else $error("pointer moved idle");
	cfg_cause_a: assert property ($changed(config_out) |-> config_wr || $past(config_wr))
		else $error("config changed unasked");
	wr_target_a: assert property (config_wr |-> pointer_out == 2'h1)
		else $error("write not to config");
	wr_framed_a: assert property (config_wr |-> busy) else $error("write outside frame");
	// moving data while the clock is high would look like a start or stop
	sda_still_a: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data moved with clock high");
	cfg_pulse_a: assert property (config_wr |=> !config_wr) else $error("long write pulse");
	sda_low_a: assert property (!sda_out) else $error("data driven high");
endmodule // aira_i2c_target_properties
`default_nettype wire

// ### sim/aira_i2c_ctrl_model.sv
// bus controller model driving clock and data of the target
`timescale 1ns/1ps
`default_nettype none
module aira_i2c_ctrl_model (
	input  wire logic       ref_clk,
	input  wire logic       scl_oe,
	input  wire logic       sda_oe,
	output wire logic       scl_line,
	output wire logic       sda_line,
	output var  logic       got,
	output var  logic [7:0] val
);
	logic scl_r = 1'b1; // only the controller clocks the bus
	logic low_r = 1'b0; // controller pulling data low
	// open-drain lines with pull-ups
	assign scl_line = scl_r && !scl_oe;
	assign sda_line = !(low_r || sda_oe);
	initial got = 1'b0;
	initial val = 8'h00;
	task tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// data held 110ns past clock fall so a data strap decodes
	task bit_x(input logic b, output logic r);
		tick(11);
		low_r <= !b;
		tick(4);
		scl_r <= 1'b1;
		tick(4);
		@(negedge ref_clk) r = sda_line;
		@(posedge ref_clk) scl_r <= 1'b0;
	endtask
	task put(input logic [7:0] v);
		val <= v;
		got <= 1'b1;
		@(posedge ref_clk) got <= 1'b0;
	endtask
	task start;
		tick(4);
		low_r <= 1'b1;
		tick(4);
		scl_r <= 1'b0;
	endtask
	task stop;
		tick(11);
		low_r <= 1'b1;
		tick(4);
		scl_r <= 1'b1;
		tick(4);
		low_r <= 1'b0;
		tick(4);
	endtask
	task wbyte(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, r);
		put({7'h00, r});
	endtask
	// last byte is refused so the target lets go
	task rbyte(input logic last);
		logic [7:0] d;
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
		bit_x(last, r);
		put(d);
	endtask
endmodule // aira_i2c_ctrl_model
`default_nettype wire

// ### sim/aira_i2c_target_tb.sv
// self-checking bench for the converter i2c target
`timescale 1ns/1ps
`default_nettype none
`include "aira_defines.vh"
module aira_i2c_target_tb;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [1:0]  addr_sel = 2'h0;
	logic [15:0] result_data = 16'h0000;
	wire         scl_line, sda_line, scl_out, scl_oe, sda_out, sda_oe, config_wr, busy, got;
	wire  [15:0] config_out;
	wire  [1:0]  pointer_out;
	wire  [7:0]  val;
	int          err_count = 0;
	int          checks_done = 0;
	logic [15:0] exp_q[$]; // bus bytes and acks awaited
	logic [15:0] cfg_q[$]; // register writes awaited
	logic [6:0]  own;      // address picked by the strap
	logic [15:0] d, r;
	always #5 ref_clk = ~ref_clk;
	aira_i2c_target dut (.ref_clk, .rst_n, .addr_sel, .scl_in(scl_line), .scl_out, .scl_oe,
		.sda_in(sda_line), .sda_out, .sda_oe, .result_data, .config_out, .config_wr,
		.pointer_out, .busy);
	aira_i2c_ctrl_model m (.ref_clk, .scl_oe, .sda_oe, .scl_line, .sda_line, .got, .val);
	task chk(input logic [15:0] e, input logic [15:0] a);
		checks_done++;
		if (a !== e) begin
			err_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask
	// results settle by the falling edge
	always @(negedge ref_clk) begin
		if (got === 1'b1) chk(exp_q.pop_front(), {8'h00, val});
		if (config_wr === 1'b1) chk(cfg_q.pop_front(), config_out);
	end
	task wr(input logic [7:0] b, input logic [15:0] e);
		exp_q.push_back(e);
		m.wbyte(b);
	endtask
	// pointer-only write, then a separate read frame
	task rd(input logic [7:0] p, input logic [15:0] e);
		m.start();
		wr({own, 1'b0}, 16'h0000);
		wr(p, 16'h0000);
		m.stop();
		chk({14'h0000, p[1:0]}, {14'h0000, pointer_out});
		m.start();
		wr({own, 1'b1}, 16'h0000);
		exp_q.push_back({8'h00, e[15:8]});
		m.rbyte(1'b0);
		exp_q.push_back({8'h00, e[7:0]});
		m.rbyte(1'b1);
		m.stop();
	endtask
	task wrap_up;
		// results still awaited mean the bus hung or lost a byte
		if (exp_q.size() != 0 || cfg_q.size() != 0)
			err_count++;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		void'($urandom(89));
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (5000) @(posedge ref_clk); // power-up wait
		for (int s = 0; s < 4; s++) begin
			// mid-run reset so the strap is taken again
			addr_sel <= s[1:0];
			rst_n <= 1'b0;
			repeat (5) @(posedge ref_clk);
			rst_n <= 1'b1;
			repeat (3) @(posedge ref_clk);
			own = `AIRA_ADDR_GND + s[6:0];
			d = 16'($urandom);
			m.start();
			wr({own, 1'b0}, 16'h0000);
			wr(8'h01, 16'h0000);
			wr(d[15:8], 16'h0000);
			cfg_q.push_back(d);
			wr(d[7:0], 16'h0000);
			m.stop();
			m.start();
			wr({own ^ 7'h01, 1'b0}, 16'h0001);
			m.stop();
			r = 16'($urandom);
			result_data <= r;
			rd(8'h00, r);
			rd(8'h01, d);
			rd(8'h02, 16'h0000);
		end
		wrap_up();
	end
	initial begin
		// the tests take about 20000 cycles; twice that means a hang
		#400000;
		err_count++;
		wrap_up();
	end
endmodule // aira_i2c_target_tb
bind aira_i2c_target aira_i2c_target_properties chk_i (.ref_clk, .rst_n, .addr_sel, .scl_in,
	.scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe, .result_data, .config_out, .config_wr,
	.pointer_out, .busy);
`default_nettype wire
